/* design/tsync_pkg.sv */
// Summary of operation
// - Sixteen compare events, each raised when the counter equals its compare value.
// - Two sync outputs, each driven to a pin and used internally.
// - Sync modes: cyclic, single shot, cyclic with ack, single shot with ack.
// - Router sends one selected sync signal to pins, cores and internal users.
// - The timer latch input is fed from a router output.
// - Controller emits one sync per loop; receiver captures it and corrects its counter.
// - Both chips use the same timer clock rate and increment, four per cycle.
// - Each realtime core has its own independent task manager.
// - Task manager has general-purpose mode and receive/transmit mode.
// - On a trigger, save program counter and flags, load the new task address.
// - On the terminate instruction, restore the last saved program counter and flags.
// - Tasks map to compare, capture and interrupt router host events.
// - With wrap enabled the counter returns to zero on matching compare zero.
// - Sync high time is the pulse width field plus one cycles in the two modes without ack.
// - Sync enables set and cyclic enable cleared gives single-shot sync A.
// - An enabled latch event copies the counter to the capture slot and flags it.
package tsync_pkg;
    localparam int CNT_W = 32;
    localparam int N_CMP = 16;
    localparam int N_CORE = 2;
    localparam int N_SLOT = 4;
    localparam int N_HOST = 8;
    localparam int PC_W = 16;
    localparam int FLAG_W = 8;
    localparam int HPW_W = 10;
    localparam logic [7:0] INC_RESET = 8'h04;
    localparam logic [CNT_W-1:0] CNT_START = 32'h00000000;
    // Event vector layout seen by every task manager.
    localparam int EVT_W = 32;
    localparam int EVT_CMP_LSB = 0;
    localparam int EVT_HOST_LSB = 16;
    localparam int EVT_CAP_BIT = 24;
    localparam logic [4:0] SEL_W_ZERO = 5'h00;
    // Router source codes.
    localparam logic [1:0] ROUTE_SYNC_A = 2'h0;
    localparam logic [1:0] ROUTE_SYNC_B = 2'h1;
    localparam logic [1:0] ROUTE_PIN = 2'h2;
    localparam logic [1:0] ROUTE_OFF = 2'h3;
    // Sync slots and compare used as the start trigger.
    localparam int SYNC_START_CMP = 1;
    localparam int WRAP_CMP = 0;
    localparam int RXTX_SLOTS = 2;

    typedef enum logic [1:0] {
        SYNC_CYCLIC,
        SYNC_SINGLE,
        SYNC_CYCLIC_ACK,
        SYNC_SINGLE_ACK
    } sync_mode_t;

    typedef enum logic {
        TM_GENERAL,
        TM_RXTX
    } tm_mode_t;

    typedef struct packed {
        logic en;
        logic [4:0] src;
        logic [PC_W-1:0] pc;
    } slot_cfg_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [FLAG_W-1:0] flags;
    } core_ctx_t;

    typedef struct packed {
        logic en;
        sync_mode_t mode;
    } sync_cfg_t;

    // Picks one event bit by index; used for every slot of every core.
    function automatic logic evt_pick(input logic [EVT_W-1:0] v, input logic [4:0] i);
        evt_pick = v[i];
    endfunction : evt_pick
endpackage : tsync_pkg

/* design/sync_pulse_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_gen
    import tsync_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Control.
    input wire sync_cfg_t cfg_i,
    input wire logic [HPW_W-1:0] width_i,
    input wire logic start_i,
    input wire logic ack_i,
    // Pulse.
    output logic pulse_o
);
    logic [HPW_W-1:0] cnt_r;
    logic fired_r;
    logic ack_mode;

    assign ack_mode = (cfg_i.mode == SYNC_CYCLIC_ACK) || (cfg_i.mode == SYNC_SINGLE_ACK);

    // Pulse timing; ack modes hold high until acknowledged instead of timing out.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pulse_o <= 1'b0;
            cnt_r <= '0;
            fired_r <= 1'b0;
        end
        else if (!cfg_i.en)
        begin
            // Dropping the enable re-arms single-shot modes.
            pulse_o <= 1'b0;
            fired_r <= 1'b0;
        end
        else if (pulse_o)
        begin
            if (ack_mode)
            begin
                pulse_o <= !ack_i;
            end
            else if (cnt_r == width_i)
            begin
                pulse_o <= 1'b0;
            end
            cnt_r <= cnt_r + 1'b1;
        end
        else if (start_i && !fired_r)
        begin
            pulse_o <= 1'b1;
            cnt_r <= '0;
            case (cfg_i.mode)
                SYNC_SINGLE, SYNC_SINGLE_ACK: fired_r <= 1'b1;
                default: fired_r <= 1'b0;
            endcase
        end
    end
endmodule : sync_pulse_gen
`default_nettype wire

/* design/task_manager.sv */
`timescale 1ns/1ps
`default_nettype none
module task_manager
    import tsync_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Configuration.
    input wire tm_mode_t mode_i,
    input wire slot_cfg_t [N_SLOT-1:0] slot_i,
    // Events and core.
    input wire logic [EVT_W-1:0] evt_i,
    input wire core_ctx_t core_ctx_i,
    input wire logic term_i,
    output logic load_o,
    output core_ctx_t load_ctx_o,
    output logic busy_o
);
    core_ctx_t saved_r;
    logic hit;
    logic [PC_W-1:0] hit_pc;

    // Lowest slot wins; receive/transmit mode only honours the first two.
    always_comb
    begin
        hit = 1'b0;
        hit_pc = '0;
        for (int s = N_SLOT - 1; s >= 0; s--)
        begin
            if (slot_i[s].en && evt_pick(evt_i, slot_i[s].src)
                && (mode_i == TM_GENERAL || s < RXTX_SLOTS))
            begin
                hit = 1'b1;
                hit_pc = slot_i[s].pc;
            end
        end
    end

    // One saved context; a trigger during a task is ignored so nothing is lost.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            load_o <= 1'b0;
            load_ctx_o <= '0;
            busy_o <= 1'b0;
            saved_r <= '0;
        end
        else
        begin
            load_o <= 1'b0;
            if (busy_o && term_i)
            begin
                load_o <= 1'b1;
                load_ctx_o <= saved_r;
                busy_o <= 1'b0;
            end
            else if (!busy_o && hit)
            begin
                saved_r <= core_ctx_i;
                load_o <= 1'b1;
                load_ctx_o <= '{pc: hit_pc, flags: core_ctx_i.flags};
                busy_o <= 1'b1;
            end
        end
    end
endmodule : task_manager
`default_nettype wire

/* design/timer_sync_task_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_sync_task_dispatch
    import tsync_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Counter control.
    input wire logic count_en_i,
    input wire logic [7:0] inc_i,
    input wire logic wrap_en_i,
    input wire logic comp_load_i,
    input wire logic [7:0] comp_inc_i,
    input wire logic [15:0] comp_cycles_i,
    // Compare setup.
    input wire logic [N_CMP-1:0] cmp_en_i,
    input wire logic [N_CMP-1:0][CNT_W-1:0] cmp_val_i,
    // Sync generator setup.
    input wire logic sync_en_i,
    input wire sync_cfg_t sync_a_cfg_i,
    input wire sync_cfg_t sync_b_cfg_i,
    input wire logic [HPW_W-1:0] sync_width_i,
    input wire logic [1:0] sync_ack_i,
    // Router and latch.
    input wire logic [1:0] route_sel_i,
    input wire logic latch_pin_i,
    input wire logic latch_en_i,
    input wire logic cap_clr_i,
    // Task managers.
    input wire tm_mode_t [N_CORE-1:0] tm_mode_i,
    input wire slot_cfg_t [N_CORE-1:0][N_SLOT-1:0] tm_slot_i,
    input wire core_ctx_t [N_CORE-1:0] core_ctx_i,
    input wire logic [N_CORE-1:0] core_term_i,
    input wire logic [N_HOST-1:0] host_evt_i,
    // Timer state.
    output logic [CNT_W-1:0] count_o,
    output logic [N_CMP-1:0] cmp_evt_o,
    output logic [CNT_W-1:0] cap_val_o,
    output logic cap_evt_o,
    output logic cap_valid_o,
    // Sync and router outputs.
    output logic sync_out_a_o,
    output logic sync_out_b_o,
    output logic route_pin_o,
    output logic [N_CORE-1:0] route_core_o,
    // Core context switching.
    output logic [N_CORE-1:0] core_load_o,
    output core_ctx_t [N_CORE-1:0] core_load_ctx_o,
    output logic [N_CORE-1:0] core_busy_o
);
    logic [CNT_W-1:0] count_r;
    logic [15:0] comp_left_r;
    logic [7:0] step;
    logic [CNT_W-1:0] count_nxt;
    logic sync_a;
    logic sync_b;
    logic routed;
    logic routed_q_r;
    logic [EVT_W-1:0] evt_vec;
    sync_cfg_t cfg_a;
    sync_cfg_t cfg_b;

    // Compensation swaps in a different step for a number of cycles.
    assign step = (comp_left_r != 16'h0000) ? comp_inc_i : inc_i;

    // Wrap on compare zero sets the cycle period.
    always_comb
    begin
        if (wrap_en_i && count_r == cmp_val_i[WRAP_CMP])
        begin
            count_nxt = CNT_START;
        end
        else
        begin
            count_nxt = count_r + {24'h000000, step};
        end
    end

    // Free-running counter; the step is applied every cycle while enabled, except on a wrap, which loads zero.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_r <= CNT_START;
        end
        else if (count_en_i)
        begin
            count_r <= count_nxt;
        end
    end

    // Compensation window; a new load restarts it without pausing the count.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            comp_left_r <= 16'h0000;
        end
        else if (comp_load_i)
        begin
            comp_left_r <= comp_cycles_i;
        end
        else if (comp_left_r != 16'h0000 && count_en_i)
        begin
            comp_left_r <= comp_left_r - 16'h0001;
        end
    end

    // Count mirror so the port comes from a flop.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_o <= CNT_START;
        end
        else
        begin
            count_o <= count_r;
        end
    end

    // One pulse per matching compare slot.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cmp_evt_o <= '0;
        end
        else
        begin
            for (int i = 0; i < N_CMP; i++)
            begin
                cmp_evt_o[i] <= cmp_en_i[i] && count_en_i
                    && (count_r == cmp_val_i[i]);
            end
        end
    end

    // The global enable gates both channels; each keeps its own mode.
    assign cfg_a = '{en: sync_en_i && sync_a_cfg_i.en, mode: sync_a_cfg_i.mode};
    assign cfg_b = '{en: sync_en_i && sync_b_cfg_i.en, mode: sync_b_cfg_i.mode};

    // Two channels started by the compare-one event.
    sync_pulse_gen u_sync_a (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg_i(cfg_a),
        .width_i(sync_width_i),
        .start_i(cmp_evt_o[SYNC_START_CMP]),
        .ack_i(sync_ack_i[0]),
        .pulse_o(sync_a)
    );

    sync_pulse_gen u_sync_b (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg_i(cfg_b),
        .width_i(sync_width_i),
        .start_i(cmp_evt_o[SYNC_START_CMP]),
        .ack_i(sync_ack_i[1]),
        .pulse_o(sync_b)
    );

    // Router source select; the off code parks every recipient low.
    always_comb
    begin
        case (route_sel_i)
            ROUTE_SYNC_A: routed = sync_a;
            ROUTE_SYNC_B: routed = sync_b;
            ROUTE_PIN: routed = latch_pin_i;
            default: routed = 1'b0;
        endcase
    end

    // Pin and per-core fan-out, plus the sync pins for other devices.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync_out_a_o <= 1'b0;
            sync_out_b_o <= 1'b0;
            route_pin_o <= 1'b0;
            route_core_o <= '0;
            routed_q_r <= 1'b0;
        end
        else
        begin
            sync_out_a_o <= sync_a;
            sync_out_b_o <= sync_b;
            route_pin_o <= routed;
            route_core_o <= {N_CORE{routed}};
            routed_q_r <= routed;
        end
    end

    // Latch on the rising edge of the routed signal; the edge is taken
    // against the delayed copy so a long pulse captures only once.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cap_val_o <= '0;
            cap_evt_o <= 1'b0;
        end
        else
        begin
            cap_evt_o <= 1'b0;
            if (latch_en_i && routed && !routed_q_r)
            begin
                cap_val_o <= count_r;
                cap_evt_o <= 1'b1;
            end
        end
    end

    // Sticky capture flag; a new capture wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cap_valid_o <= 1'b0;
        end
        else if (latch_en_i && routed && !routed_q_r)
        begin
            cap_valid_o <= 1'b1;
        end
        else if (cap_clr_i)
        begin
            cap_valid_o <= 1'b0;
        end
    end

    // Event vector shared by all task managers.
    always_comb
    begin
        evt_vec = '0;
        evt_vec[EVT_CMP_LSB +: N_CMP] = cmp_evt_o;
        evt_vec[EVT_HOST_LSB +: N_HOST] = host_evt_i;
        evt_vec[EVT_CAP_BIT] = cap_evt_o;
    end

    // Firmware must save any other core registers it touches; only the
    // program counter and flags are kept here.
    for (genvar c = 0; c < N_CORE; c++)
    begin : g_core
        task_manager u_tm (
            .clk_sys_i(clk_sys_i),
            .resetn_i(resetn_i),
            .mode_i(tm_mode_i[c]),
            .slot_i(tm_slot_i[c]),
            .evt_i(evt_vec),
            .core_ctx_i(core_ctx_i[c]),
            .term_i(core_term_i[c]),
            .load_o(core_load_o[c]),
            .load_ctx_o(core_load_ctx_o[c]),
            .busy_o(core_busy_o[c])
        );
    end
endmodule : timer_sync_task_dispatch
`default_nettype wire

/* verification/tsync_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tsync_checker
    import tsync_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Watched inputs.
    input wire logic count_en_i,
    input wire logic wrap_en_i,
    input wire logic [N_CMP-1:0] cmp_en_i,
    input wire sync_cfg_t sync_a_cfg_i,
    input wire logic [HPW_W-1:0] sync_width_i,
    input wire logic [1:0] route_sel_i,
    input wire logic latch_pin_i,
    input wire logic latch_en_i,
    input wire logic [N_CORE-1:0] core_term_i,
    // Watched outputs.
    input wire logic [CNT_W-1:0] count_o,
    input wire logic [N_CMP-1:0] cmp_evt_o,
    input wire logic cap_evt_o,
    input wire logic cap_valid_o,
    input wire logic sync_out_a_o,
    input wire logic [N_CORE-1:0] core_load_o,
    input wire logic [N_CORE-1:0] core_busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [10:0] high_r;
    // Times each sync pulse alone; cleared while low so a long gap never leaks into it.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i) high_r <= 11'h000;
        else if (sync_out_a_o) high_r <= high_r + 11'h001;
        else high_r <= 11'h000;
    end
    // A task starts with a load and busy together; a return loads with busy dropped.
    sequence s_start;
        core_load_o[0] && core_busy_o[0];
    endsequence
    sequence s_back;
        core_load_o[0] && !core_busy_o[0];
    endsequence
    a_wrap_zero: assert property (cmp_evt_o[0] && wrap_en_i && count_en_i |=> count_o == CNT_START)
        else $error("counter did not wrap after compare zero");
    a_cmp_enabled: assert property (cmp_evt_o[1] |-> $past(cmp_en_i[1]))
        else $error("compare event from a disabled compare");
    a_sync_width: assert property ($fell(sync_out_a_o) && !sync_a_cfg_i.mode[1]
        |-> high_r == {1'b0, sync_width_i} + 11'h001)
        else $error("sync pulse width wrong");
    a_sync_cause: assert property ($rose(sync_out_a_o) |-> $past(cmp_evt_o[SYNC_START_CMP], 2))
        else $error("sync pulse without compare one");
    a_cap_take: assert property (latch_en_i && route_sel_i == ROUTE_PIN && $rose(latch_pin_i)
        |=> cap_evt_o)
        else $error("latch edge not captured");
    a_cap_pulse: assert property (cap_evt_o |-> cap_valid_o ##1 !cap_evt_o)
        else $error("capture event malformed");
    a_task_start: assert property ($rose(core_busy_o[0]) |-> s_start)
        else $error("task start without load");
    a_task_return: assert property (core_busy_o[0] && core_term_i[0] |=> s_back)
        else $error("terminate did not restore");
    a_load_once: assert property (core_load_o[0] |=> !core_load_o[0])
        else $error("load pulse longer than one cycle");
endmodule : tsync_checker

bind timer_sync_task_dispatch tsync_checker u_chk (.clk_sys_i, .resetn_i, .count_en_i,
    .wrap_en_i, .cmp_en_i, .sync_a_cfg_i, .sync_width_i, .route_sel_i, .latch_pin_i,
    .latch_en_i, .core_term_i, .count_o, .cmp_evt_o, .cap_evt_o, .cap_valid_o,
    .sync_out_a_o, .core_load_o, .core_busy_o);
`default_nettype wire

/* verification/peer_sync_model.sv */
`timescale 1ns/1ps
`default_nettype none
module peer_sync_model #(
    parameter int PERIOD = 40,
    parameter int HIGH = 10
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Control and pin.
    input wire logic run_i,
    output logic sync_o
);
    int n;
    // The peer runs off the same timer clock, one pulse per loop period.
    always @(negedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i || !run_i)
        begin
            n <= 0;
            sync_o <= 1'b0;
        end
        else
        begin
            sync_o <= (n < HIGH);
            n <= (n == PERIOD - 1) ? 0 : n + 1;
        end
    end
endmodule : peer_sync_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tsync_pkg::*;
    logic clk_sys_i, resetn_i, count_en_i, wrap_en_i, comp_load_i, sync_en_i, latch_pin_i;
    logic latch_en_i, cap_clr_i, peer_run, cap_evt_o, cap_valid_o, sync_out_a_o;
    logic sync_out_b_o, route_pin_o;
    logic [7:0] inc_i, comp_inc_i;
    logic [15:0] comp_cycles_i;
    logic [N_CMP-1:0] cmp_en_i, cmp_evt_o;
    logic [N_CMP-1:0][CNT_W-1:0] cmp_val_i;
    sync_cfg_t sync_a_cfg_i, sync_b_cfg_i;
    logic [HPW_W-1:0] sync_width_i;
    logic [1:0] sync_ack_i, route_sel_i;
    tm_mode_t [N_CORE-1:0] tm_mode_i;
    slot_cfg_t [N_CORE-1:0][N_SLOT-1:0] tm_slot_i;
    core_ctx_t [N_CORE-1:0] core_ctx_i, core_load_ctx_o;
    logic [N_CORE-1:0] core_term_i, route_core_o, core_load_o, core_busy_o;
    logic [N_HOST-1:0] host_evt_i;
    logic [CNT_W-1:0] count_o, cap_val_o;
    int n_fail, n_tests;

    timer_sync_task_dispatch dut (.clk_sys_i, .resetn_i, .count_en_i, .inc_i, .wrap_en_i,
        .comp_load_i, .comp_inc_i, .comp_cycles_i, .cmp_en_i, .cmp_val_i, .sync_en_i,
        .sync_a_cfg_i, .sync_b_cfg_i, .sync_width_i, .sync_ack_i, .route_sel_i, .latch_pin_i,
        .latch_en_i, .cap_clr_i, .tm_mode_i, .tm_slot_i, .core_ctx_i, .core_term_i,
        .host_evt_i, .count_o, .cmp_evt_o, .cap_val_o, .cap_evt_o, .cap_valid_o,
        .sync_out_a_o, .sync_out_b_o, .route_pin_o, .route_core_o, .core_load_o,
        .core_load_ctx_o, .core_busy_o);
    peer_sync_model #(.PERIOD(40), .HIGH(10)) u_peer (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .run_i(peer_run), .sync_o(latch_pin_i));

    // Free-running bench clock at 50 ns.
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // A bounded wait that ran out ends the run at once.
    task automatic need(input logic ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            test_done();
        end
    endtask : need
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    // Step, hold, then a three-cycle compensation window of step 8; the extra
    // twelve keeps the count a multiple of four so later compares still hit.
    task automatic t_count();
        logic [31:0] a;
        cyc(2);
        a = count_o;
        cyc(1);
        chk(count_o - a, 32'h00000004);
        count_en_i = 1'b0;
        cyc(2);
        a = count_o;
        cyc(3);
        chk(count_o - a, 32'h00000000);
        count_en_i = 1'b1;
        comp_inc_i = 8'h08;
        comp_cycles_i = 16'h0003;
        cyc(2);
        a = count_o;
        comp_load_i = 1'b1;
        cyc(1);
        comp_load_i = 1'b0;
        cyc(11);
        chk(count_o - a, 32'h0000003C);
    endtask : t_count

    // Every sync mode on both channels; single modes must stay quiet afterwards.
    task automatic t_sync();
        int i, k;
        logic s;
        sync_width_i = 10'h009;
        sync_en_i = 1'b1;
        for (k = 0; k < 4; k++)
        begin
            // A cyclic-ack pulse left from the last mode stays high until acknowledged.
            if (sync_out_a_o)
            begin
                sync_ack_i = 2'h3;
                for (i = 0; i < 40 && sync_out_a_o; i++) cyc(1);
                sync_ack_i = 2'h0;
            end
            need(sync_out_a_o === 1'b0);
            sync_a_cfg_i = '{en: 1'b0, mode: sync_mode_t'(k)};
            sync_b_cfg_i = sync_a_cfg_i;
            cyc(2);
            sync_a_cfg_i.en = 1'b1;
            sync_b_cfg_i.en = 1'b1;
            for (i = 0; i < 200 && sync_out_a_o !== 1'b1; i++) cyc(1);
            need(sync_out_a_o);
            if (k >= 2)
            begin
                cyc(14);
                chk(sync_out_a_o, 32'h1);
                sync_ack_i = 2'h3;
                for (i = 0; i < 4 && sync_out_a_o; i++) cyc(1);
                chk(sync_out_a_o, 32'h0);
                sync_ack_i = 2'h0;
            end
            else
            begin
                for (i = 0; i < 40 && sync_out_a_o; i++)
                begin
                    chk(sync_out_b_o, sync_out_a_o);
                    cyc(1);
                end
                chk(i, 32'hA);
            end
            s = 1'b0;
            repeat (80)
            begin
                cyc(1);
                s = s | sync_out_a_o;
            end
            chk(s, (k % 2) ? 32'h0 : 32'h1);
        end
        sync_a_cfg_i.en = 1'b0;
        sync_b_cfg_i.en = 1'b0;
    endtask : t_sync

    // Peer pulses captured with the counter frozen; routing off must block them.
    task automatic t_cap();
        int i;
        logic s;
        count_en_i = 1'b0;
        route_sel_i = ROUTE_PIN;
        latch_en_i = 1'b1;
        peer_run = 1'b1;
        for (i = 0; i < 100 && cap_evt_o !== 1'b1; i++) cyc(1);
        need(cap_evt_o);
        chk(cap_val_o, count_o);
        chk(cap_valid_o, 32'h1);
        chk({route_core_o, route_pin_o}, 32'h7);
        cap_clr_i = 1'b1;
        cyc(1);
        cap_clr_i = 1'b0;
        cyc(1);
        chk(cap_valid_o, 32'h0);
        route_sel_i = ROUTE_OFF;
        s = 1'b0;
        repeat (100)
        begin
            cyc(1);
            s = s | cap_evt_o | route_pin_o | (|route_core_o);
        end
        chk(s, 32'h0);
        peer_run = 1'b0;
        count_en_i = 1'b1;
    endtask : t_cap

    // Core 0 on compare zero, core 1 on a host event, then both return.
    task automatic t_task();
        int i, c;
        logic s;
        tm_slot_i[0][0] = '{en: 1'b1, src: 5'h00, pc: 16'h1234};
        tm_slot_i[1][0] = '{en: 1'b1, src: 5'h10, pc: 16'h0777};
        tm_slot_i[1][2] = '{en: 1'b1, src: 5'h11, pc: 16'h0999};
        tm_mode_i[1] = TM_RXTX;
        for (i = 0; i < 200 && core_load_o[0] !== 1'b1; i++) cyc(1);
        need(core_load_o[0]);
        chk(core_load_ctx_o[0], {16'h1234, 8'h5A});
        // The task's firmware overwrites core state itself; only pc and flags come back.
        core_ctx_i[0] = '{pc: 16'h1240, flags: 8'h00};
        // Receive/transmit mode on core 1 must ignore the trigger of slot two.
        host_evt_i = 8'h02;
        cyc(3);
        chk(core_busy_o[1], 32'h0);
        host_evt_i = 8'h01;
        for (i = 0; i < 20 && core_load_o[1] !== 1'b1; i++) cyc(1);
        need(core_load_o[1]);
        host_evt_i = 8'h00;
        chk(core_load_ctx_o[1], {16'h0777, 8'h3C});
        chk(core_busy_o, 32'h3);
        s = 1'b0;
        repeat (70)
        begin
            cyc(1);
            s = s | core_load_o[0];
        end
        chk(s, 32'h0);
        tm_slot_i[0][0].en = 1'b0;
        tm_slot_i[1][0].en = 1'b0;
        for (c = 0; c < 2; c++)
        begin
            core_term_i[c] = 1'b1;
            cyc(1);
            core_term_i[c] = 1'b0;
            for (i = 0; i < 10 && core_load_o[c] !== 1'b1; i++) cyc(1);
            need(core_load_o[c]);
            chk(core_load_ctx_o[c], c ? {16'h0100, 8'h3C} : {16'hABCD, 8'h5A});
            chk(core_busy_o[c], 32'h0);
        end
    endtask : t_task

    // Reset, then the scenarios in turn.
    initial
    begin
        n_fail = 0;
        n_tests = 0;
        {resetn_i, comp_load_i, sync_en_i, latch_en_i, cap_clr_i, peer_run} = 6'h00;
        {count_en_i, wrap_en_i} = 2'h3;
        inc_i = INC_RESET;
        {comp_inc_i, comp_cycles_i} = 24'h000000;
        cmp_en_i = 16'h0003;
        cmp_val_i = '0;
        cmp_val_i[0] = 32'h000000FC;
        cmp_val_i[1] = 32'h00000028;
        sync_a_cfg_i = '0;
        sync_b_cfg_i = '0;
        sync_width_i = 10'h009;
        {sync_ack_i, route_sel_i} = 4'h2;
        tm_mode_i[0] = TM_GENERAL;
        tm_mode_i[1] = TM_GENERAL;
        tm_slot_i = '0;
        core_ctx_i[0] = '{pc: 16'hABCD, flags: 8'h5A};
        core_ctx_i[1] = '{pc: 16'h0100, flags: 8'h3C};
        core_term_i = 2'h0;
        host_evt_i = 8'h00;
        cyc(6);
        resetn_i = 1'b1;
        t_count();
        t_sync();
        t_cap();
        t_task();
        test_done();
    end
endmodule : tb
`default_nettype wire
